// ---- pkg/pcf_pkg.sv ----
// How it works
// - Reads return an error-check byte; master checks
// - Alert line pulled; answers the alert query
// - Only storable settings go to non-volatile store
// - Linear word: 11-bit mantissa, 5-bit exponent
// - Address is two octal strap digits, 0-63
// - Bad strap digit gives fallback address 127
// - Works at 100 kHz and 400 kHz
// - Run control bit 7 requests output on
// - Startup config: bits 4-1 writable, 0 read-only
// - Power-up bit clear: start whenever powered
// - Power-up bit set: wait for whichever of pin and command is enabled
// - Command-response bit gates the run enable bit
// - Pin-response bit demands the on/off pin
// - Soft-start accepts any rise mantissa 0-511
// - Soft-start exponent -4, top mantissa bits zero
// - Divider ratio exponent fixed at -9
// - Divider mantissa defaults 256, max 512
// - Trim acts through the reference setting
// - Trim steps 0.4 percent within 25 percent
// - Out-of-window trim: nominal, alert, error flags
package pcf_pkg;
   localparam logic [7:0] CMD_RUN_CONTROL = 8'h01;
   localparam logic [7:0] CMD_STARTUP_CONFIG = 8'h02;
   localparam logic [7:0] CMD_STORE_ALL = 8'h11;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_VOUT_TRIM = 8'h22;
   localparam logic [7:0] CMD_DIVIDER_RATIO = 8'h29;
   localparam logic [7:0] CMD_SOFT_START = 8'h61;
   localparam logic [7:0] CMD_COMMUNICATION_ERROR_STATUS = 8'h7e;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
   localparam logic [6:0] FALLBACK_ADDR = 7'h7f;
   localparam int RUN_ON_BIT = 7;
   localparam int CFG_PU_BIT = 4;
   localparam int CFG_CMD_BIT = 3;
   localparam int CFG_CPR_BIT = 2;
   localparam int CFG_POL_BIT = 1;
   localparam logic [7:0] CFG_WR_MASK = 8'h1e;
   localparam logic [7:0] RUN_CONTROL_RST = 8'h80;
   localparam logic [7:0] STARTUP_CONFIG_RST = 8'h17;
   localparam logic [4:0] SS_EXP = 5'h1c;
   localparam logic [15:0] SOFT_START_RST = 16'he015;
   localparam logic [4:0] DIV_EXP = 5'h17;
   localparam logic [10:0] DIV_MANT_RST = 11'h100;
   localparam logic [10:0] DIV_MANT_MAX = 11'h200;
   localparam logic [15:0] TRIM_MAX = 16'h3fff;
   localparam logic [15:0] TRIM_MIN = 16'hc000;
   localparam logic [7:0] CML_INVALID_DATA = 8'h40;
   localparam logic [7:0] CML_BAD_PEC = 8'h20;
   localparam logic [7:0] CML_BAD_CMD = 8'h80;
endpackage

// ---- src/pcf_frontend.sv ----
`timescale 1ns/10ps
module pcf_frontend
   import pcf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic alert_out,
   output logic alert_oe,
   input wire logic [3:0] address_high_digit_pin,
   input wire logic [3:0] address_low_digit_pin,
   input wire logic on_off_pin,
   output logic output_enable,
   output logic [15:0] soft_start_time,
   output logic [15:0] divider_ratio,
   output logic [15:0] reference_trim,
   output logic store_request,
   output logic [7:0] communication_error_status
);
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ACK = 7'h04,
      ST_RX = 7'h08,
      ST_TX = 7'h10,
      ST_TXACK = 7'h20,
      ST_SKIP = 7'h40
   } pcf_state_t;
   logic [1:0] scl_s, sda_s, pin_s;
   logic [3:0] hi_s1, hi_s2, lo_s1, lo_s2;
   logic scl_d1, sda_d1;
   logic scl_rise, scl_fall, start_c, stop_c;
   pcf_state_t st_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [2:0] byte_q;
   logic rd_q, ara_q;
   logic [7:0] cmd_q, d0_q, d1_q, crc_q, tx_q;
   logic [6:0] my_addr;
   logic [7:0] run_control_q, startup_config_q;
   logic [15:0] trim_q;
   logic alert_q;
   logic [7:0] crc_next;
   logic [7:0] rsp_lo, rsp_hi;
   logic [2:0] need_q;

   // Two-stage synchronisers; logic reads only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         pin_s <= 2'h0;
         scl_d1 <= 1'b1;
         sda_d1 <= 1'b1;
         hi_s1 <= 4'h0;
         hi_s2 <= 4'h0;
         lo_s1 <= 4'h0;
         lo_s2 <= 4'h0;
      end else begin
         scl_s <= {scl_s[0], scl_in};
         sda_s <= {sda_s[0], sda_in};
         pin_s <= {pin_s[0], on_off_pin};
         scl_d1 <= scl_s[1];
         sda_d1 <= sda_s[1];
         hi_s1 <= address_high_digit_pin;
         hi_s2 <= hi_s1;
         lo_s1 <= address_low_digit_pin;
         lo_s2 <= lo_s1;
      end
   end
   // Edge detection on the oversampled link clock works at both speeds
   assign scl_rise = scl_s[1] & ~scl_d1;
   assign scl_fall = ~scl_s[1] & scl_d1;
   assign start_c = scl_s[1] & scl_d1 & sda_d1 & ~sda_s[1];
   assign stop_c = scl_s[1] & scl_d1 & ~sda_d1 & sda_s[1];

   // Address from octal straps, fallback on a bad digit
   always_comb begin
      if (hi_s2 > 4'h7 || lo_s2 > 4'h7)
         my_addr = FALLBACK_ADDR;
      else
         my_addr = {1'b0, hi_s2[2:0], lo_s2[2:0]};
   end

   // CRC-8, polynomial x8+x2+x+1, over the shifted byte
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++)
         r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
      return r;
   endfunction
   assign crc_next = crc8(crc_q, sh_q);

   // Read response words
   always_comb begin
      rsp_hi = 8'h00;
      case (cmd_q)
         CMD_RUN_CONTROL: rsp_lo = run_control_q;
         CMD_STARTUP_CONFIG: rsp_lo = startup_config_q;
         CMD_COMMUNICATION_ERROR_STATUS: rsp_lo = communication_error_status;
         CMD_SOFT_START: begin
            rsp_lo = soft_start_time[7:0];
            rsp_hi = soft_start_time[15:8];
         end
         CMD_DIVIDER_RATIO: begin
            rsp_lo = divider_ratio[7:0];
            rsp_hi = divider_ratio[15:8];
         end
         CMD_VOUT_TRIM: begin
            rsp_lo = trim_q[7:0];
            rsp_hi = trim_q[15:8];
         end
         default: rsp_lo = 8'hff;
      endcase
   end

   // Data bytes a write of this command carries
   always_comb begin
      case (cmd_q)
         CMD_RUN_CONTROL, CMD_STARTUP_CONFIG: need_q = 3'h1;
         CMD_SOFT_START, CMD_DIVIDER_RATIO, CMD_VOUT_TRIM: need_q = 3'h2;
         default: need_q = 3'h0;
      endcase
   end

   logic ack_byte;
   logic commit;
   logic [7:0] pec_fail;
   // Byte engine
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         byte_q <= 3'h0;
         rd_q <= 1'b0;
         ara_q <= 1'b0;
         cmd_q <= 8'h00;
         d0_q <= 8'h00;
         d1_q <= 8'h00;
         crc_q <= 8'h00;
         tx_q <= 8'h00;
         ack_byte <= 1'b0;
      end else if (start_c) begin
         st_q <= ST_ADDR;
         bit_q <= 4'h0;
         // A repeated start keeps the check running over the whole transaction
         if (st_q == ST_IDLE || st_q == ST_SKIP)
            crc_q <= 8'h00;
         ack_byte <= 1'b0;
      end else if (stop_c) begin
         st_q <= ST_IDLE;
         ack_byte <= 1'b0;
      end else begin
         case (st_q)
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_s[1]};
                  bit_q <= bit_q + 4'h1;
               end
               if (scl_fall && bit_q == 4'h8) begin
                  bit_q <= 4'h0;
                  crc_q <= crc_next;
                  if (st_q == ST_ADDR) begin
                     if (sh_q[7:1] == my_addr) begin
                        rd_q <= sh_q[0];
                        ara_q <= 1'b0;
                        if (!sh_q[0])
                           byte_q <= 3'h0;
                        st_q <= ST_ACK;
                        ack_byte <= 1'b1;
                     end else if (sh_q[7:1] == ALERT_RESP_ADDR && sh_q[0] && alert_q) begin
                        rd_q <= 1'b1;
                        ara_q <= 1'b1;
                        st_q <= ST_ACK;
                        ack_byte <= 1'b1;
                     end else
                        st_q <= ST_SKIP;
                  end else begin
                     case (byte_q)
                        3'h0: cmd_q <= sh_q;
                        3'h1: d0_q <= sh_q;
                        3'h2: d1_q <= sh_q;
                        default: ;
                     endcase
                     byte_q <= (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
                     st_q <= ST_ACK;
                     ack_byte <= 1'b1;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  ack_byte <= 1'b0;
                  if (rd_q) begin
                     st_q <= ST_TX;
                     tx_q <= ara_q ? {my_addr, 1'b1} : rsp_lo;
                     byte_q <= 3'h0;
                  end else
                     st_q <= ST_RX;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  bit_q <= bit_q + 4'h1;
                  tx_q <= {tx_q[6:0], 1'b0};
                  if (bit_q == 4'h7) begin
                     bit_q <= 4'h0;
                     st_q <= ST_TXACK;
                  end
               end
               if (scl_rise && bit_q == 4'h0)
                  sh_q <= tx_q;
            end
            ST_TXACK: begin
               if (scl_rise && sda_s[1])
                  st_q <= ST_SKIP;
               else if (scl_fall) begin
                  st_q <= ST_TX;
                  crc_q <= crc8(crc_q, sh_q);
                  byte_q <= byte_q + 3'h1;
                  // Word reads send high byte, then the error-check byte
                  if (!ara_q && byte_q == 3'h0 && (cmd_q == CMD_SOFT_START || cmd_q == CMD_DIVIDER_RATIO ||
                      cmd_q == CMD_VOUT_TRIM))
                     tx_q <= rsp_hi;
                  else
                     tx_q <= crc8(crc_q, sh_q);
               end
            end
            default: ;
         endcase
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe = ack_byte | (st_q == ST_TX && !tx_q[7]);

   // Write commits only at stop after a matching error-check byte
   assign commit = stop_c && !rd_q && (st_q == ST_ACK || st_q == ST_RX) && byte_q == need_q + 3'h2
      && crc_q == 8'h00;
   assign pec_fail = (stop_c && !rd_q && (st_q == ST_ACK || st_q == ST_RX) && byte_q == need_q + 3'h2
      && crc_q != 8'h00) ? CML_BAD_PEC : 8'h00;

   logic [10:0] div_m;
   logic trim_bad;
   assign div_m = {d1_q[2:0], d0_q};
   assign trim_bad = ({d1_q, d0_q} > TRIM_MAX) && ({d1_q, d0_q} < TRIM_MIN);

   // Settings, all volatile
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_control_q <= RUN_CONTROL_RST;
         startup_config_q <= STARTUP_CONFIG_RST;
         soft_start_time <= SOFT_START_RST;
         divider_ratio <= {DIV_EXP, DIV_MANT_RST};
         trim_q <= 16'h0000;
         reference_trim <= 16'h0000;
         store_request <= 1'b0;
      end else begin
         store_request <= commit && cmd_q == CMD_STORE_ALL;
         if (commit) begin
            case (cmd_q)
               CMD_RUN_CONTROL: run_control_q <= d0_q;
               CMD_STARTUP_CONFIG:
                  startup_config_q <= (startup_config_q & ~CFG_WR_MASK) | (d0_q & CFG_WR_MASK);
               CMD_SOFT_START:
                  if (d1_q[7:3] == SS_EXP && d1_q[2:1] == 2'h0)
                     soft_start_time <= {d1_q, d0_q};
               CMD_DIVIDER_RATIO:
                  if (d1_q[7:3] == DIV_EXP && div_m <= DIV_MANT_MAX)
                     divider_ratio <= {d1_q, d0_q};
               CMD_VOUT_TRIM: begin
                  trim_q <= {d1_q, d0_q};
                  reference_trim <= trim_bad ? 16'h0000 : {d1_q, d0_q};
               end
               default: ;
            endcase
         end
      end
   end

   // Status and alert; hardware set wins over clear
   logic bad_trim_ev, bad_cmd_ev;
   assign bad_trim_ev = commit && cmd_q == CMD_VOUT_TRIM && trim_bad;
   assign bad_cmd_ev = commit && need_q == 3'h0 && cmd_q != CMD_STORE_ALL && cmd_q != CMD_CLEAR_FAULTS;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         communication_error_status <= 8'h00;
         alert_q <= 1'b0;
      end else begin
         if (commit && cmd_q == CMD_CLEAR_FAULTS) begin
            communication_error_status <= 8'h00;
            alert_q <= 1'b0;
         end
         if (ara_q && st_q == ST_TXACK && scl_fall)
            alert_q <= 1'b0;
         if (bad_trim_ev || bad_cmd_ev || pec_fail != 8'h00) begin
            communication_error_status <= communication_error_status | pec_fail |
               (bad_trim_ev ? CML_INVALID_DATA : 8'h00) | (bad_cmd_ev ? CML_BAD_CMD : 8'h00);
            alert_q <= 1'b1;
         end
      end
   end
   assign alert_out = 1'b0;
   assign alert_oe = alert_q;

   // Output enable decision
   logic pin_ok, cmd_ok;
   always_comb begin
      pin_ok = !startup_config_q[CFG_CPR_BIT] ||
               (pin_s[1] == startup_config_q[CFG_POL_BIT]);
      cmd_ok = !startup_config_q[CFG_CMD_BIT] || run_control_q[RUN_ON_BIT];
      output_enable = !startup_config_q[CFG_PU_BIT] || (pin_ok && cmd_ok);
   end

   a_pu_clear_on: assert property (@(posedge clk) disable iff (rst)
      !startup_config_q[CFG_PU_BIT] |-> output_enable) else $error("output off with power-up bit clear");
   a_cmd_gate: assert property (@(posedge clk) disable iff (rst)
      startup_config_q[CFG_PU_BIT] && startup_config_q[CFG_CMD_BIT] && !run_control_q[RUN_ON_BIT]
      |-> !output_enable) else $error("enable ignored run bit");
   a_pin_gate: assert property (@(posedge clk) disable iff (rst)
      startup_config_q[CFG_PU_BIT] && startup_config_q[CFG_CPR_BIT] && pin_s[1] != startup_config_q[CFG_POL_BIT]
      |-> !output_enable) else $error("enable ignored on/off pin");
   a_addr_fallback: assert property (@(posedge clk) disable iff (rst)
      hi_s2[3] || lo_s2[3] |-> my_addr == FALLBACK_ADDR) else $error("no fallback address");
   a_cfg_ro_bit: assert property (@(posedge clk) disable iff (rst)
      startup_config_q[0] == $past(startup_config_q[0])) else $error("read-only bit changed");
   a_run_write: assert property (@(posedge clk) disable iff (rst)
      commit && cmd_q == CMD_RUN_CONTROL |=> run_control_q == $past(d0_q)) else $error("run control not written");
   a_div_max: assert property (@(posedge clk) disable iff (rst)
      divider_ratio[10:0] <= DIV_MANT_MAX) else $error("divider mantissa too large");
   a_div_exp: assert property (@(posedge clk) disable iff (rst)
      divider_ratio[15:11] == DIV_EXP) else $error("divider exponent wrong");
   a_ss_exp: assert property (@(posedge clk) disable iff (rst)
      soft_start_time[15:11] == SS_EXP && soft_start_time[10:9] == 2'h0) else $error("soft-start format");
   a_trim_revert: assert property (@(posedge clk) disable iff (rst)
      bad_trim_ev |=> reference_trim == 16'h0000 && alert_oe) else $error("bad trim not reverted");
   a_pec_discard: assert property (@(posedge clk) disable iff (rst)
      pec_fail != 8'h00 |=> $stable(run_control_q) && $stable(startup_config_q)) else $error("bad check wrote");
   a_store_pulse: assert property (@(posedge clk) disable iff (rst)
      store_request |=> !store_request) else $error("store request longer than one cycle");
endmodule

// ---- sim/pcf_host_model.sv ----
`timescale 1ns/10ps
module pcf_host_model (
   output logic scl,
   output logic sda_pull,
   input wire logic sda_line
);
   int low_extra = 0;
   logic [7:0] crc;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
      return r;
   endfunction
   // Data moves only while the link clock is low
   task automatic bit_io(input logic v, output logic s);
      sda_pull = ~v;
      #(50 + low_extra);
      scl = 1'b1;
      #50 s = sda_line;
      #50 scl = 1'b0;
      #50;
   endtask
   task automatic tx(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      crc = crc8(crc, b);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic rx(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      crc = crc8(crc, b);
      bit_io(last, s);
   endtask
   task automatic start();
      sda_pull = 1'b0;
      #50 scl = 1'b1;
      #100 sda_pull = 1'b1;
      #100 scl = 1'b0;
      #50;
   endtask
   task automatic stop();
      sda_pull = 1'b1;
      #50 scl = 1'b1;
      #100 sda_pull = 1'b0;
      #100;
   endtask
   task automatic write_frame(input logic [6:0] a, input logic [7:0] cmd, input int n, input logic [15:0] d,
                              input bit bad, output logic ok);
      logic k;
      crc = 8'h00;
      start();
      tx({a, 1'b0}, ok);
      if (ok) begin
         tx(cmd, k);
         if (n > 0) tx(d[7:0], k);
         if (n > 1) tx(d[15:8], k);
         tx(crc ^ {7'h00, bad}, k);
      end
      stop();
   endtask
   // A query skips the command phase and reads at once
   task automatic read_frame(input logic [6:0] a, input logic [7:0] cmd, input int n, input bit query,
                             output logic [15:0] d, output logic ok);
      logic k;
      logic [7:0] p;
      logic [7:0] e;
      crc = 8'h00;
      d = 16'h0000;
      start();
      if (!query) begin
         tx({a, 1'b0}, k);
         tx(cmd, k);
         start();
      end
      tx({a, 1'b1}, k);
      rx(1'b0, d[7:0]);
      if (n > 1) rx(1'b0, d[15:8]);
      e = crc;
      rx(1'b1, p);
      stop();
      ok = (p === e);
   endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import pcf_pkg::*;
   logic clk, rst, scl, host_pull, on_off_pin, sda_out, sda_oe, alert_out, alert_oe, output_enable, store_request;
   logic [3:0] hi_pin, lo_pin;
   logic [15:0] soft_start_time, divider_ratio, reference_trim, m_ss, m_div, m_trim, rd;
   logic [7:0] communication_error_status, m_run, m_cfg, m_cml;
   logic [6:0] addr, tgt;
   logic m_alert, ok;
   logic [10:0] ss_tab [8] = '{11'd10, 11'd14, 11'd19, 11'd29, 11'd43, 11'd67, 11'd96, 11'd144};
   int bad_count = 0;
   int checks = 0;
   int m_store = 0;
   int d_store = 0;
   int seed = 32'hec6eed67;
   wire sda_line;
   assign sda_line = ~(host_pull | sda_oe);
   pcf_frontend pcf_frontend_inst (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe), .address_high_digit_pin(hi_pin),
      .address_low_digit_pin(lo_pin), .on_off_pin(on_off_pin), .output_enable(output_enable),
      .soft_start_time(soft_start_time), .divider_ratio(divider_ratio), .reference_trim(reference_trim),
      .store_request(store_request), .communication_error_status(communication_error_status));
   pcf_host_model pcf_host_model_inst (.scl(scl), .sda_pull(host_pull), .sda_line(sda_line));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) if (store_request === 1'b1) d_store <= d_store + 1;
   task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_bit(input string what, input logic e, input logic g);
      chk_val(what, {15'h0000, e}, {15'h0000, g});
   endtask
   function automatic logic en_model();
      if (!m_cfg[CFG_PU_BIT]) return 1'b1;
      return (m_cfg[CFG_CMD_BIT] ? m_run[RUN_ON_BIT] : 1'b1) &
             (m_cfg[CFG_CPR_BIT] ? on_off_pin == m_cfg[CFG_POL_BIT] : 1'b1);
   endfunction
   task automatic cmp_all();
      chk_val("soft_start", m_ss, soft_start_time);
      chk_val("divider", m_div, divider_ratio);
      chk_val("trim", m_trim, reference_trim);
      chk_val("status", {8'h00, m_cml}, {8'h00, communication_error_status});
      chk_bit("alert", m_alert, alert_oe);
      chk_bit("enable", en_model(), output_enable);
      chk_val("store", 16'(m_store), 16'(d_store));
      chk_val("drive_low", 16'h0000, {14'h0000, sda_out, alert_out});
   endtask
   task automatic bw(input logic [7:0] cmd, input int n, input logic [15:0] d, input bit bad);
      logic a;
      pcf_host_model_inst.write_frame(tgt, cmd, n, d, bad, a);
      chk_bit("addr_ack", tgt == addr, a);
      if (a && bad) begin
         m_cml = m_cml | CML_BAD_PEC;
         m_alert = 1'b1;
      end else if (a) begin
         case (cmd)
            CMD_RUN_CONTROL: m_run = d[7:0];
            CMD_STARTUP_CONFIG: m_cfg = (m_cfg & ~CFG_WR_MASK) | (d[7:0] & CFG_WR_MASK);
            CMD_SOFT_START: if (d[15:11] == SS_EXP && d[10:9] == 2'b00) m_ss = d;
            CMD_DIVIDER_RATIO: if (d[15:11] == DIV_EXP && d[10:0] <= DIV_MANT_MAX) m_div = d;
            CMD_VOUT_TRIM: if ($signed(d) > $signed(TRIM_MAX) || $signed(d) < $signed(TRIM_MIN)) begin
               m_trim = 16'h0000;
               m_cml = m_cml | CML_INVALID_DATA;
               m_alert = 1'b1;
            end else m_trim = d;
            CMD_CLEAR_FAULTS: begin
               m_cml = 8'h00;
               m_alert = 1'b0;
            end
            CMD_STORE_ALL: m_store++;
            default: if (n == 0) begin
               m_cml = m_cml | CML_BAD_CMD;
               m_alert = 1'b1;
            end
         endcase
      end
      repeat (8) @(negedge clk);
      cmp_all();
   endtask
   task automatic br(input logic [7:0] cmd, input int n, input logic [15:0] e);
      pcf_host_model_inst.read_frame(addr, cmd, n, 1'b0, rd, ok);
      chk_val("read", e, rd);
      chk_bit("read_pec", 1'b1, ok);
   endtask
   task automatic final_report();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #2400000;
      bad_count++;
      $display("mismatch watchdog expected done seen hang");
      final_report();
   end
   initial begin
      rst = 1'b1;
      on_off_pin = 1'b0;
      hi_pin = 4'd2 + 4'($random(seed) & 1);
      lo_pin = 4'($random(seed) & 7);
      addr = 7'({hi_pin[2:0], lo_pin[2:0]});
      tgt = addr;
      m_run = RUN_CONTROL_RST;
      m_cfg = STARTUP_CONFIG_RST;
      m_ss = SOFT_START_RST;
      m_div = {DIV_EXP, DIV_MANT_RST};
      m_trim = 16'h0000;
      m_cml = 8'h00;
      m_alert = 1'b0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      cmp_all();
      br(CMD_RUN_CONTROL, 1, {8'h00, RUN_CONTROL_RST});
      br(CMD_STARTUP_CONFIG, 1, {8'h00, STARTUP_CONFIG_RST});
      for (int c = 0; c < 16; c++) begin
         bw(CMD_STARTUP_CONFIG, 1, 16'(c * 2 + ($random(seed) & 32'he1)), 1'b0);
         br(CMD_STARTUP_CONFIG, 1, {8'h00, m_cfg});
         for (int r = 0; r < 2; r++) begin
            bw(CMD_RUN_CONTROL, 1, 16'(r * 128), 1'b0);
            on_off_pin = ~on_off_pin;
            repeat (6) @(negedge clk);
            chk_bit("enable_pin", en_model(), output_enable);
         end
      end
      foreach (ss_tab[i]) bw(CMD_SOFT_START, 2, {SS_EXP, ss_tab[i]}, 1'b0);
      bw(CMD_SOFT_START, 2, {5'h1d, 11'd14}, 1'b0);
      bw(CMD_SOFT_START, 2, {SS_EXP, 11'h60e}, 1'b0);
      bw(CMD_DIVIDER_RATIO, 2, {DIV_EXP, DIV_MANT_MAX}, 1'b0);
      br(CMD_DIVIDER_RATIO, 2, m_div);
      bw(CMD_DIVIDER_RATIO, 2, {DIV_EXP, 11'h201}, 1'b0);
      bw(CMD_DIVIDER_RATIO, 2, {5'h18, 11'h100}, 1'b0);
      bw(CMD_STORE_ALL, 0, 16'h0000, 1'b0);
      bw(CMD_RUN_CONTROL, 1, 16'h0000, 1'b1);
      bw(CMD_VOUT_TRIM, 2, 16'h3fff, 1'b0);
      bw(CMD_VOUT_TRIM, 2, 16'hc000, 1'b0);
      bw(CMD_VOUT_TRIM, 2, 16'h4000, 1'b0);
      bw(CMD_COMMUNICATION_ERROR_STATUS, 0, 16'h0000, 1'b0);
      pcf_host_model_inst.read_frame(ALERT_RESP_ADDR, 8'h00, 1, 1'b1, rd, ok);
      m_alert = 1'b0;
      chk_val("alert_id", {8'h00, addr, 1'b1}, rd);
      chk_bit("alert_pec", 1'b1, ok);
      br(CMD_COMMUNICATION_ERROR_STATUS, 1, {8'h00, m_cml});
      bw(CMD_CLEAR_FAULTS, 0, 16'h0000, 1'b0);
      tgt = addr ^ 7'h01;
      bw(CMD_RUN_CONTROL, 1, 16'h0000, 1'b0);
      tgt = addr;
      pcf_host_model_inst.low_extra = 9800;
      bw(CMD_RUN_CONTROL, 1, 16'h0080, 1'b0);
      br(CMD_RUN_CONTROL, 1, {8'h00, m_run});
      pcf_host_model_inst.low_extra = 0;
      hi_pin = 4'd8 | 4'($random(seed) & 7);
      addr = FALLBACK_ADDR;
      tgt = addr;
      repeat (4) @(negedge clk);
      bw(CMD_SOFT_START, 2, {SS_EXP, 11'd10}, 1'b0);
      final_report();
   end
endmodule
